// ===== tma_pkg.sv
package tma_pkg;
	localparam int CNT_W = 16;
	localparam int NUM_CH = 4;
	localparam int MODE_W = 4;
	localparam int EDGE_W = 2;
	// channel modes
	localparam logic [MODE_W-1:0] MODE_INTERVAL = 4'h0;
	localparam logic [MODE_W-1:0] MODE_SQUARE = 4'h1;
	localparam logic [MODE_W-1:0] MODE_EVENT = 4'h2;
	localparam logic [MODE_W-1:0] MODE_DIVIDER = 4'h3;
	localparam logic [MODE_W-1:0] MODE_PULSE_IVL = 4'h4;
	localparam logic [MODE_W-1:0] MODE_WIDTH = 4'h5;
	localparam logic [MODE_W-1:0] MODE_DELAY = 4'h6;
	localparam logic [MODE_W-1:0] MODE_ONESHOT_M = 4'h7;
	localparam logic [MODE_W-1:0] MODE_ONESHOT_S = 4'h8;
	localparam logic [MODE_W-1:0] MODE_PWM_M = 4'h9;
	localparam logic [MODE_W-1:0] MODE_PWM_S = 4'ha;
	// valid edge select
	localparam logic [EDGE_W-1:0] EDGE_FALL = 2'h0;
	localparam logic [EDGE_W-1:0] EDGE_RISE = 2'h1;
	localparam logic [EDGE_W-1:0] EDGE_BOTH = 2'h2;
	// channel that may run the divider
	localparam int DIVIDER_CH = 0;
	// reset values and the counter maximum
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] DATA_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic OUT_RST = 1'b0;
endpackage

// ===== tma_edge_sync.sv
`timescale 1ns/1ps
module tma_edge_sync
#(
	parameter int N = 4
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// raw pins
	input wire logic [N-1:0] pin_i,
	// edge pulses
	output logic [N-1:0] rise_o,
	output logic [N-1:0] fall_o
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] rise;
		logic [N-1:0] fall;
	} tma_sync_t;

	tma_sync_t sync_reg;
	tma_sync_t sync_next;

	// s1 feeds only s2; edges come from s2 against s3
	always_comb
	begin
		sync_next = sync_reg;
		sync_next.s1 = pin_i;
		sync_next.s2 = sync_reg.s1;
		sync_next.s3 = sync_reg.s2;
		sync_next.rise = sync_reg.s2 & ~sync_reg.s3;
		sync_next.fall = ~sync_reg.s2 & sync_reg.s3;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync_reg <= '0;
		end
		else
		begin
			sync_reg <= sync_next;
		end
	end

	assign rise_o = sync_reg.rise;
	assign fall_o = sync_reg.fall;
endmodule // tma_edge_sync

// ===== tma_timer_array.sv
`timescale 1ns/1ps
// Functional notes
// - four channels, each a 16-bit counter, each usable as its own timer.
// - each channel has one counter register, one data register, one input pin and one output pin.
// - channels link to the nearest lower master so several work as one timer.
// - interval mode raises the channel interrupt at a fixed period.
// - square wave mode toggles the output pin on every channel interrupt.
// - event mode counts valid input edges and interrupts when the programmed count is reached.
// - divider mode on the first channel divides the input pin clock onto its output pin.
// - pulse interval mode starts on a valid edge and captures on the next valid edge.
// - width mode starts on one edge and captures on the opposite edge.
// - delay mode starts on a valid edge and interrupts after the programmed delay.
// - one-shot mode pairs a delay master and a width slave for a single pulse.
// - pwm mode pairs a period master and a duty slave for a pulse train.
// - multiple pwm lets one master drive the period of several duty slaves.
// - interrupt sources are compare match or capture; overflow and underflow are flagged on their own outputs.
module tma_timer_array
	import tma_pkg::*;
#(
	parameter int N = tma_pkg::NUM_CH
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// channel configuration
	input wire logic [N-1:0] enable_i,
	input wire logic [N-1:0][tma_pkg::MODE_W-1:0] mode_i,
	input wire logic [N-1:0][tma_pkg::EDGE_W-1:0] edge_sel_i,
	// data register write
	input wire logic [N-1:0] data_wr_i,
	input wire logic [N-1:0][tma_pkg::CNT_W-1:0] data_wdata_i,
	// pins
	input wire logic [N-1:0] channel_input_pin_i,
	output logic [N-1:0] channel_output_pin_o,
	// interrupts and status
	output logic [N-1:0] channel_interrupt_o,
	output logic [N-1:0] overflow_o,
	output logic [N-1:0] underflow_o,
	output logic [N-1:0][tma_pkg::CNT_W-1:0] counter_o,
	output logic [N-1:0][tma_pkg::CNT_W-1:0] data_o
);
	import tma_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ARMED = 3'b010,
		ST_RUN = 3'b100
	} tma_state_t;

	typedef struct packed {
		tma_state_t [N-1:0] st;
		logic [N-1:0][CNT_W-1:0] cnt;
		logic [N-1:0][CNT_W-1:0] data;
		logic [N-1:0] out;
		logic [N-1:0] irq;
		logic [N-1:0] ovf;
		logic [N-1:0] udf;
		logic [N-1:0] trig;
	} tma_regs_t;

	tma_regs_t state_reg;
	tma_regs_t state_next;
	logic [N-1:0] rise;
	logic [N-1:0] fall;

	// pins are asynchronous, so two flops before any edge logic
	tma_edge_sync #(.N(N)) u_sync
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(channel_input_pin_i),
		.rise_o(rise),
		.fall_o(fall)
	);

	function automatic logic edge_hit(input logic r, input logic f, input logic [EDGE_W-1:0] sel);
		case (sel)
			EDGE_RISE: edge_hit = r;
			EDGE_FALL: edge_hit = f;
			EDGE_BOTH: edge_hit = r | f;
			default: edge_hit = 1'b0;
		endcase
	endfunction

	function automatic logic [EDGE_W-1:0] opposite(input logic [EDGE_W-1:0] sel);
		case (sel)
			EDGE_RISE: opposite = EDGE_FALL;
			EDGE_FALL: opposite = EDGE_RISE;
			default: opposite = sel;
		endcase
	endfunction

	function automatic logic is_master(input logic [MODE_W-1:0] m);
		is_master = (m == MODE_PWM_M) || (m == MODE_ONESHOT_M);
	endfunction

	always_comb
	begin
		logic lnk, ev, opp;
		lnk = 1'b0;
		ev = 1'b0;
		opp = 1'b0;
		state_next = state_reg;
		state_next.irq = '0;
		state_next.ovf = '0;
		state_next.udf = '0;
		state_next.trig = '0;
		for (int i = 0; i < N; i++)
		begin
			// slaves follow the trigger of the nearest master below them
			if (is_master(mode_i[i]))
				lnk = state_reg.trig[i];
			ev = edge_hit(rise[i], fall[i], edge_sel_i[i]);
			opp = edge_hit(rise[i], fall[i], opposite(edge_sel_i[i]));
			if (data_wr_i[i])
				state_next.data[i] = data_wdata_i[i];
			if (!enable_i[i])
			begin
				state_next.st[i] = ST_IDLE;
				state_next.cnt[i] = CNT_RST;
				state_next.out[i] = OUT_RST;
			end
			else
			begin
				case (state_reg.st[i])
					ST_IDLE:
					begin
						case (mode_i[i])
							MODE_INTERVAL, MODE_SQUARE, MODE_PWM_M, MODE_EVENT:
							begin
								state_next.cnt[i] = state_reg.data[i];
								state_next.st[i] = ST_RUN;
								state_next.trig[i] = (mode_i[i] == MODE_PWM_M);
							end
							MODE_DIVIDER:
							begin
								// divider only exists on the first channel
								if (i == DIVIDER_CH)
								begin
									state_next.cnt[i] = state_reg.data[i];
									state_next.st[i] = ST_RUN;
								end
							end
							MODE_PULSE_IVL, MODE_WIDTH, MODE_DELAY, MODE_ONESHOT_M, MODE_ONESHOT_S, MODE_PWM_S:
								state_next.st[i] = ST_ARMED;
							default: state_next.st[i] = ST_IDLE;
						endcase
					end
					ST_ARMED:
					begin
						case (mode_i[i])
							MODE_PULSE_IVL, MODE_WIDTH:
							begin
								if (ev)
								begin
									state_next.cnt[i] = CNT_RST;
									state_next.st[i] = ST_RUN;
								end
							end
							MODE_DELAY, MODE_ONESHOT_M:
							begin
								if (ev)
								begin
									state_next.cnt[i] = state_reg.data[i];
									state_next.st[i] = ST_RUN;
								end
							end
							MODE_ONESHOT_S:
							begin
								if (lnk)
								begin
									state_next.cnt[i] = state_reg.data[i];
									state_next.out[i] = 1'b1;
									state_next.st[i] = ST_RUN;
								end
							end
							MODE_PWM_S:
							begin
								if (lnk)
								begin
									state_next.st[i] = ST_RUN;
									state_next.out[i] = (state_reg.data[i] != CNT_RST);
									state_next.cnt[i] = state_reg.data[i] - 16'h0001;
								end
							end
							default: state_next.st[i] = ST_IDLE;
						endcase
					end
					ST_RUN:
					begin
						case (mode_i[i])
							MODE_INTERVAL, MODE_SQUARE, MODE_PWM_M:
							begin
								if (state_reg.cnt[i] == CNT_RST)
								begin
									state_next.cnt[i] = state_reg.data[i];
									state_next.irq[i] = 1'b1;
									state_next.udf[i] = 1'b1;
									state_next.trig[i] = (mode_i[i] == MODE_PWM_M);
									if (mode_i[i] == MODE_SQUARE)
										state_next.out[i] = ~state_reg.out[i];
								end
								else
									state_next.cnt[i] = state_reg.cnt[i] - 16'h0001;
							end
							MODE_EVENT, MODE_DIVIDER:
							begin
								if (ev && state_reg.cnt[i] == CNT_RST)
								begin
									state_next.cnt[i] = state_reg.data[i];
									state_next.irq[i] = 1'b1;
									if (mode_i[i] == MODE_DIVIDER)
										state_next.out[i] = ~state_reg.out[i];
								end
								else if (ev)
									state_next.cnt[i] = state_reg.cnt[i] - 16'h0001;
							end
							MODE_PULSE_IVL, MODE_WIDTH:
							begin
								// capture beats a same-cycle host write
								if ((mode_i[i] == MODE_PULSE_IVL) ? ev : opp)
								begin
									state_next.data[i] = state_reg.cnt[i];
									state_next.irq[i] = 1'b1;
									state_next.cnt[i] = CNT_RST;
									if (mode_i[i] == MODE_WIDTH)
										state_next.st[i] = ST_ARMED;
								end
								else
								begin
									state_next.cnt[i] = state_reg.cnt[i] + 16'h0001;
									state_next.ovf[i] = (state_reg.cnt[i] == CNT_MAX);
								end
							end
							MODE_DELAY, MODE_ONESHOT_M, MODE_ONESHOT_S:
							begin
								if (state_reg.cnt[i] == CNT_RST)
								begin
									state_next.irq[i] = 1'b1;
									state_next.trig[i] = (mode_i[i] == MODE_ONESHOT_M);
									state_next.out[i] = 1'b0;
									state_next.st[i] = ST_ARMED;
								end
								else
									state_next.cnt[i] = state_reg.cnt[i] - 16'h0001;
							end
							MODE_PWM_S:
							begin
								// duty restarts on every master period
								if (lnk)
								begin
									state_next.out[i] = (state_reg.data[i] != CNT_RST);
									state_next.cnt[i] = state_reg.data[i] - 16'h0001;
								end
								else if (state_reg.cnt[i] != CNT_RST)
									state_next.cnt[i] = state_reg.cnt[i] - 16'h0001;
								else if (state_reg.out[i])
								begin
									state_next.out[i] = 1'b0;
									state_next.irq[i] = 1'b1;
								end
							end
							default: state_next.st[i] = ST_IDLE;
						endcase
					end
					default: state_next.st[i] = ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < N; i++)
				state_reg.st[i] <= ST_IDLE;
			state_reg.cnt <= {N{CNT_RST}};
			state_reg.data <= {N{DATA_RST}};
			state_reg.out <= '0;
			state_reg.irq <= '0;
			state_reg.ovf <= '0;
			state_reg.udf <= '0;
			state_reg.trig <= '0;
		end
		else
			state_reg <= state_next;
	end

	assign channel_output_pin_o = state_reg.out;
	assign channel_interrupt_o = state_reg.irq;
	assign overflow_o = state_reg.ovf;
	assign underflow_o = state_reg.udf;
	assign counter_o = state_reg.cnt;
	assign data_o = state_reg.data;
endmodule // tma_timer_array

// ===== tma_pin_model.sv
`timescale 1ns/1ps
module tma_pin_model
(
	// clock
	input wire logic clk_i,
	// burst control
	input wire logic en_i,
	input wire logic [3:0] half_i,
	input wire logic [3:0] rises_i,
	// pin
	output logic pin_o
);
	logic [3:0] c_reg;
	logic [3:0] r_reg;
	// idles low like a pulled-down pin; a burst always ends low
	// half_i of 3 or more keeps each level past the synchroniser
	always_ff @(posedge clk_i)
	begin
		if (!en_i)
		begin
			pin_o <= 1'b0;
			c_reg <= 4'h0;
			r_reg <= 4'h0;
		end
		else if (c_reg != half_i - 4'h1)
			c_reg <= c_reg + 4'h1;
		else if (r_reg < rises_i || pin_o)
		begin
			c_reg <= 4'h0;
			pin_o <= !pin_o;
			r_reg <= r_reg + 4'(!pin_o);
		end
	end
endmodule // tma_pin_model

// ===== tma_timer_array_sva.sv
`timescale 1ns/1ps
module tma_timer_array_sva
	import tma_pkg::*;
#(
	parameter int N = 4
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// configuration
	input wire logic [N-1:0] enable_i,
	input wire logic [N-1:0][tma_pkg::MODE_W-1:0] mode_i,
	input wire logic [N-1:0] data_wr_i,
	input wire logic [N-1:0][tma_pkg::CNT_W-1:0] data_wdata_i,
	// outputs
	input wire logic [N-1:0] channel_output_pin_o,
	input wire logic [N-1:0] channel_interrupt_o,
	input wire logic [N-1:0] underflow_o,
	input wire logic [N-1:0][tma_pkg::CNT_W-1:0] counter_o,
	input wire logic [N-1:0][tma_pkg::CNT_W-1:0] data_o
);
	logic [15:0] gap_reg;
	logic arm_reg;
	// gap trusted only after one undisturbed period
	always_ff @(posedge clk_i)
	begin
		gap_reg <= channel_interrupt_o[0] ? 16'h0001 : gap_reg + 16'h0001;
		arm_reg <= !rst_i && enable_i[0] && !data_wr_i[0] && mode_i[0] == MODE_INTERVAL
			&& (arm_reg || channel_interrupt_o[0]);
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	idle_when_off_a: assert property (!enable_i[0] |=> counter_o[0] == 16'h0000 && !channel_output_pin_o[0]
		&& !channel_interrupt_o[0]) else $error("channel not idle while disabled");
	data_write_a: assert property (data_wr_i[0] && mode_i[0] == MODE_INTERVAL
		|=> data_o[0] == $past(data_wdata_i[0])) else $error("data write lost");
	interval_gap_a: assert property (channel_interrupt_o[0] && arm_reg
		|-> gap_reg == data_o[0] + 16'h0001) else $error("interval period wrong");
	square_toggle_a: assert property ($changed(channel_output_pin_o[0]) && $past(enable_i[0])
		&& $past(mode_i[0]) == MODE_SQUARE |-> channel_interrupt_o[0]) else $error("toggle without interrupt");
	reload_irq_a: assert property (underflow_o[0] && mode_i[0] == MODE_INTERVAL
		|-> channel_interrupt_o[0]) else $error("reload without interrupt");
	pwm_duty_a: assert property ($rose(channel_output_pin_o[1]) && mode_i[1] == MODE_PWM_S && data_o[1] == 16'h0003
		|-> channel_output_pin_o[1][*3] ##1 !channel_output_pin_o[1]) else $error("duty length wrong");
	capture_irq_a: assert property ($changed(data_o[1]) && !$past(data_wr_i[1])
		|-> channel_interrupt_o[1]) else $error("capture without interrupt");
	slave_pulse_a: assert property (channel_interrupt_o[2] && mode_i[2] == MODE_PWM_S
		|=> !channel_interrupt_o[2]) else $error("slave interrupt too long");
	cover property (channel_interrupt_o[0] && arm_reg);
	cover property ($rose(channel_output_pin_o[1]));
	cover property ($changed(data_o[1]) && channel_interrupt_o[1]);
endmodule // tma_timer_array_sva
bind tma_timer_array tma_timer_array_sva #(.N(N)) u_sva (.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i),
	.mode_i(mode_i), .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i),
	.channel_output_pin_o(channel_output_pin_o), .channel_interrupt_o(channel_interrupt_o),
	.underflow_o(underflow_o), .counter_o(counter_o), .data_o(data_o));

// ===== test_multi_mode_timer_array.sv
`timescale 1ns/1ps
module test_multi_mode_timer_array;
	import tma_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] en = 4'h0;
	logic [3:0] wr = 4'h0;
	logic [3:0][3:0] md = '0;
	logic [3:0][1:0] es = '0;
	logic [3:0][15:0] wd = '0;
	logic pe = 1'b0;
	logic [3:0] ph = 4'h3;
	logic [3:0] pr = 4'h1;
	logic pin;
	logic [3:0] out, irq, ovf, unf;
	logic [3:0][15:0] cnt, dat;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	int hi, ni, nt, k;
	int exp_hi[4] = '{0, 12, 20, 0};
	tma_timer_array #(.N(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .enable_i(en), .mode_i(md), .edge_sel_i(es),
		.data_wr_i(wr), .data_wdata_i(wd), .channel_input_pin_i({4{pin}}), .channel_output_pin_o(out),
		.channel_interrupt_o(irq), .overflow_o(ovf), .underflow_o(unf), .counter_o(cnt), .data_o(dat));
	tma_pin_model u_pin (.clk_i(clk_i), .en_i(pe), .half_i(ph), .rises_i(pr), .pin_o(pin));
	initial
	begin
		forever #20 clk_i = !clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 70000)
		begin
			n_fail++;
			end_of_test();
		end
	end
	task end_of_test();
		$display("checks %0d fails %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			#1;
		end
	endtask
	// mode and data only change while the channel is stopped
	task setup(input int ch, input logic [3:0] m, input logic [15:0] d);
		md[ch] = m;
		es[ch] = EDGE_RISE;
		wr[ch] = 1'b1;
		wd[ch] = d;
		tick(1);
		wr[ch] = 1'b0;
	endtask
	task watch(input int ch, input int n);
		logic o;
		hi = 0;
		ni = 0;
		nt = 0;
		repeat (n)
		begin
			o = out[ch];
			tick(1);
			hi += (out[ch] === 1'b1);
			ni += (irq[ch] === 1'b1);
			nt += (out[ch] !== o);
		end
	endtask
	task wait_irq(input int ch);
		k = 0;
		do
		begin
			tick(1);
			k++;
		end
		while (irq[ch] !== 1'b1 && k < 100);
	endtask
	task stop();
		en = 4'h0;
		pe = 1'b0;
		tick(2);
	endtask
	task burst(input int ch, input logic [3:0] h, input logic [3:0] r, input int n);
		ph = h;
		pr = r;
		pe = 1'b1;
		watch(ch, n);
	endtask
	task t_write();
		for (int i = 0; i < 4; i++)
		begin
			setup(i, MODE_INTERVAL, 16'ha5c0 + 16'(i));
			chk(dat[i], 16'ha5c0 + 16'(i));
		end
		$display("write done");
	endtask
	task t_interval();
		setup(0, MODE_INTERVAL, 16'h0004);
		en[0] = 1'b1;
		wait_irq(0);
		wait_irq(0);
		chk(k, 5);
		chk(unf[0], 1'b1);
		stop();
		$display("interval done");
	endtask
	task t_square();
		logic o;
		setup(0, MODE_SQUARE, 16'h0002);
		en[0] = 1'b1;
		wait_irq(0);
		o = out[0];
		wait_irq(0);
		chk(out[0], !o);
		chk(k, 3);
		stop();
		$display("square done");
	endtask
	task t_count(input logic [3:0] m, input logic [1:0] e, input int n);
		setup(0, m, 16'h0001);
		es[0] = e;
		en[0] = 1'b1;
		burst(0, 4'h3, 4'ha, 75);
		chk(ni, n);
		if (m == MODE_DIVIDER)
			chk(nt, n);
		stop();
		$display("count done");
	endtask
	task t_capture(input logic [3:0] m, input logic [15:0] e, input int n);
		setup(1, m, 16'h0000);
		en[1] = 1'b1;
		burst(1, 4'h5, 4'h4, 60);
		chk(dat[1], e);
		chk(ni, n);
		stop();
		$display("capture done");
	endtask
	task t_overflow();
		setup(1, MODE_PULSE_IVL, 16'h0000);
		en[1] = 1'b1;
		burst(1, 4'h4, 4'h1, 20);
		chk(ni, 0);
		chk(cnt[1], 16'h000c);
		// single edge, so the up count starts at the eighth edge and runs to the wrap
		tick((1 << CNT_W) - 13);
		chk({ovf[1], cnt[1]}, {1'b0, CNT_MAX});
		tick(1);
		chk({ovf[1], irq[1], cnt[1]}, {2'b10, CNT_RST});
		stop();
		$display("overflow done");
	endtask
	task t_delay();
		setup(2, MODE_DELAY, 16'h0006);
		en[2] = 1'b1;
		burst(2, 4'h4, 4'h1, 30);
		chk(ni, 1);
		stop();
		$display("delay done");
	endtask
	task t_pwm();
		setup(0, MODE_PWM_M, 16'h0009);
		setup(1, MODE_PWM_S, 16'h0003);
		setup(2, MODE_PWM_S, 16'h0005);
		setup(3, MODE_PWM_S, 16'h0000);
		en = 4'hf;
		tick(25);
		for (int i = 1; i < 4; i++)
		begin
			watch(i, 40);
			chk(hi, exp_hi[i]);
		end
		wait_irq(0);
		wait_irq(0);
		chk(k, 10);
		stop();
		$display("pwm done");
	endtask
	task t_oneshot();
		setup(0, MODE_ONESHOT_M, 16'h0003);
		setup(1, MODE_ONESHOT_S, 16'h0002);
		en = 4'h3;
		burst(1, 4'h4, 4'h1, 40);
		chk(hi, 3);
		chk(ni, 1);
		stop();
		$display("oneshot done");
	endtask
	initial
	begin
		tick(20);
		rst_i = 1'b0;
		tick(1);
		chk({out, irq, unf}, 12'h000);
		chk(dat, 64'h0);
		t_write();
		t_interval();
		t_square();
		t_count(MODE_EVENT, EDGE_RISE, 5);
		t_count(MODE_EVENT, EDGE_BOTH, 10);
		t_count(MODE_DIVIDER, EDGE_FALL, 5);
		t_capture(MODE_PULSE_IVL, 16'h0009, 3);
		t_capture(MODE_WIDTH, 16'h0004, 4);
		t_overflow();
		t_delay();
		t_pwm();
		t_oneshot();
		end_of_test();
	end
endmodule // test_multi_mode_timer_array
